// ==== common/mcsel_consts.svh ====
// Constants of the monitoring case selector
`ifndef MCSEL_CONSTS_SVH
`define MCSEL_CONSTS_SVH
// Number of monitoring cases, five control inputs give 32 conditions
`define MCSEL_NUM_CASES 32
// Width of a case index
`define MCSEL_IDX_W 5
// Number of single connections used by 1-of-n sampling
`define MCSEL_ONEN_W 10
// Field set number width, up to 16 field sets
`define MCSEL_FSET_W 4
// Multiple sampling limits and counter width
`define MCSEL_MULTI_W 5
`define MCSEL_MULTI_MIN 5'h02
`define MCSEL_MULTI_MAX 5'h10
// Contour distance width
`define MCSEL_DIST_W 16
// Reset values
`define MCSEL_RST_CASE 5'h00
`define MCSEL_RST_FSET 4'h0
`endif

// ==== common/mcsel_pkg.sv ====
// Types of the monitoring case selector
package mcsel_pkg;
  // Source of case selection information
  typedef enum logic [1:0] {SRC_STATIC, SRC_SPEED, SRC_BOTH} mcsel_src_t;
  // Permitted follow-on cases of a monitoring case
  typedef enum logic [1:0] {FOL_NONE, FOL_UNIQUE, FOL_ALT} mcsel_fol_t;
  // Monitoring state
  typedef enum logic [1:0] {ST_INIT, ST_MONITOR, ST_TRIPPED} mcsel_st_t;
  // One stored monitoring case
  typedef struct packed {
    logic valid;
    logic [3:0] fset;
    mcsel_fol_t fol;
    logic [4:0] fol_a;
    logic [4:0] fol_b;
    logic [4:0] multi;
  } mcsel_case_t;
endpackage : mcsel_pkg

// ==== src/mcsel_decode.sv ====
// Control input decoder: complementary and 1-of-n sampling
`timescale 1ns/1ps
`include "mcsel_consts.svh"
module mcsel_decode
(
  input wire logic one_of_n,
  input wire logic [`MCSEL_IDX_W-1:0] ctrl,
  input wire logic [`MCSEL_ONEN_W-1:0] pins,
  output logic [`MCSEL_IDX_W-1:0] idx,
  output logic ok
);
  // ==========================================================
  // Decode
  // ==========================================================
  logic [3:0] ones; // Number of high single connections
  logic [3:0] pos;  // Position of the last high connection
  // Count ones and locate the high connection
  always_comb
  begin
    ones = 4'h0;
    pos = 4'h0;
    idx = ctrl;
    ok = 1'b1;
    for (int i = 0; i < `MCSEL_ONEN_W; i++)
    begin
      if (pins[i])
      begin
        ones = ones + 4'h1;
        pos = 4'(i);
      end
    end
    if (one_of_n)
    begin
      idx = {1'b0, pos};
      ok = (ones == 4'h1);
    end
    else
    begin
      idx = ctrl;
      ok = 1'b1;
    end
  end
endmodule : mcsel_decode

// ==== src/mcsel_top.sv ====
// Monitoring case selector with protective field and contour trip
`timescale 1ns/1ps
`include "mcsel_consts.svh"
module mcsel_top
(
  input wire logic REF_CLK,
  input wire logic RST_B,
  input wire logic SCAN_TICK,
  input wire logic [4:0] CTRL_IN,
  input wire logic [9:0] ONE_OF_N_IN,
  input wire logic ONE_OF_N_MODE,
  input wire logic [1:0] SEL_SOURCE,
  input wire logic [4:0] SPEED_CASE,
  input wire logic SPEED_VALID,
  input wire logic CFG_WE,
  input wire logic [4:0] CFG_IDX,
  input wire logic CFG_VALID,
  input wire logic [3:0] CFG_FSET,
  input wire logic [1:0] CFG_FOLLOW,
  input wire logic [4:0] CFG_FOLLOW_A,
  input wire logic [4:0] CFG_FOLLOW_B,
  input wire logic [4:0] CFG_MULTI,
  input wire logic CFG_CONTOUR_EN,
  input wire logic CFG_WARN2_EN,
  input wire logic CFG_WARN_AT_CONTOUR,
  input wire logic OBJ_DETECT,
  input wire logic SEG_STROBE,
  input wire logic [15:0] SEG_MEAS,
  input wire logic [15:0] SEG_REF,
  input wire logic [15:0] SEG_TOL_POS,
  input wire logic [15:0] SEG_TOL_NEG,
  output logic SAFETY_SWITCH_OUTPUTS,
  output logic FIELD_INTERRUPTED,
  output logic [4:0] ACTIVE_CASE,
  output logic [3:0] ACTIVE_FSET,
  output logic INPUT_ERROR,
  output logic CONTOUR_ERROR,
  output logic CFG_REJECT
);
  // ==========================================================
  // Case store
  // ==========================================================
  mcsel_pkg::mcsel_case_t cfg_mem [`MCSEL_NUM_CASES]; // Stored cases
  mcsel_pkg::mcsel_case_t wr_ent; // Entry being written
  logic [4:0] multi_clip; // Sampling count held in legal range
  // Clip the sampling count on its way into the store
  always_comb
  begin
    multi_clip = CFG_MULTI;
    if (CFG_MULTI < `MCSEL_MULTI_MIN)
      multi_clip = `MCSEL_MULTI_MIN;
    else if (CFG_MULTI > `MCSEL_MULTI_MAX)
      multi_clip = `MCSEL_MULTI_MAX;
    wr_ent = '{valid: CFG_VALID, fset: CFG_FSET,
               fol: mcsel_pkg::mcsel_fol_t'(CFG_FOLLOW),
               fol_a: CFG_FOLLOW_A, fol_b: CFG_FOLLOW_B,
               multi: multi_clip};
  end
  // Store writes; all cases start unconfigured so nothing passes
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
      for (int i = 0; i < `MCSEL_NUM_CASES; i++)
        cfg_mem[i] <= '0;
    else if (CFG_WE)
      cfg_mem[CFG_IDX] <= wr_ent;
  end

  // ==========================================================
  // Input decode
  // ==========================================================
  logic [4:0] dec_idx; // Decoded static condition
  logic dec_ok; // Static condition well formed
  mcsel_decode u_dec
  (
    .one_of_n(ONE_OF_N_MODE),
    .ctrl(CTRL_IN),
    .pins(ONE_OF_N_IN),
    .idx(dec_idx),
    .ok(dec_ok)
  );

  // ==========================================================
  // State and next values
  // ==========================================================
  mcsel_pkg::mcsel_st_t st_reg, st_next; // Monitoring state
  logic [4:0] case_reg, case_next; // Active case index
  logic [4:0] hit_reg, hit_next; // Consecutive object scans
  logic bad_reg, bad_next; // Contour fault seen this scan
  logic safe_reg, safe_next; // Safety outputs on
  logic intr_reg, intr_next; // Interruption report to the link
  logic in_err_reg, in_err_next; // Selection fault latched
  logic cont_reg, cont_next; // Contour fault latched
  logic rej_reg, rej_next; // Configuration refused
  logic [3:0] fset_reg, fset_next; // Active field set
  logic [4:0] cand; // Candidate case this scan
  logic cand_ok; // Candidate usable
  logic fol_ok; // Candidate allowed after active case
  logic seg_bad; // Current segment out of band
  logic cont_on; // Contour monitoring accepted
  logic field_trip; // Enough consecutive object scans
  logic [4:0] hit_inc; // Saturated hit count plus one
  logic [4:0] need; // Sampling count that applies this scan
  logic [16:0] hi_lim, lo_lim; // Band limits, one bit of headroom
  mcsel_pkg::mcsel_case_t act, nxt; // Active and candidate records
  // Compute the next values of every register
  always_comb
  begin
    act = cfg_mem[case_reg];
    rej_next = CFG_CONTOUR_EN & (CFG_WARN2_EN | CFG_WARN_AT_CONTOUR);
    cont_on = CFG_CONTOUR_EN & ~rej_next;
    hi_lim = {1'b0, SEG_REF} + {1'b0, SEG_TOL_POS};
    lo_lim = {1'b0, SEG_REF} - {1'b0, SEG_TOL_NEG};
    // Underflow of the lower limit means no lower bound
    seg_bad = SEG_STROBE & cont_on &
              (({1'b0, SEG_MEAS} > hi_lim) |
               (~lo_lim[16] & ({1'b0, SEG_MEAS} < lo_lim)));
    case (mcsel_pkg::mcsel_src_t'(SEL_SOURCE))
      mcsel_pkg::SRC_STATIC:
      begin
        cand = dec_idx;
        cand_ok = dec_ok;
      end
      mcsel_pkg::SRC_SPEED:
      begin
        cand = SPEED_CASE;
        cand_ok = SPEED_VALID;
      end
      mcsel_pkg::SRC_BOTH:
      begin
        // Both sources must name the same case
        cand = dec_idx;
        cand_ok = dec_ok & SPEED_VALID & (SPEED_CASE == dec_idx);
      end
      default:
      begin
        cand = case_reg;
        cand_ok = 1'b0;
      end
    endcase
    nxt = cfg_mem[cand];
    // Follow-on check applies only once a case is running
    case (act.fol)
      mcsel_pkg::FOL_UNIQUE: fol_ok = (cand == act.fol_a);
      mcsel_pkg::FOL_ALT: fol_ok = (cand == act.fol_a) |
                                   (cand == act.fol_b);
      default: fol_ok = 1'b1;
    endcase
    if (st_reg == mcsel_pkg::ST_INIT || cand == case_reg)
      fol_ok = 1'b1;
    cand_ok = cand_ok & nxt.valid & fol_ok;
    hit_inc = (hit_reg == `MCSEL_MULTI_MAX) ? hit_reg : hit_reg + 5'h01;
    need = cand_ok ? nxt.multi : act.multi;
    // Unwritten entries hold zero; never trip on a single scan
    if (need < `MCSEL_MULTI_MIN)
      need = `MCSEL_MULTI_MIN;
    // Hold everything but the contour fault and reject flags between scan boundaries
    st_next = st_reg;
    case_next = case_reg;
    fset_next = fset_reg;
    hit_next = hit_reg;
    safe_next = safe_reg;
    in_err_next = in_err_reg;
    cont_next = cont_reg;
    field_trip = 1'b0;
    // A segment failing in the boundary cycle belongs to this scan
    bad_next = bad_reg | seg_bad;
    if (SCAN_TICK)
    begin
      bad_next = 1'b0;
      hit_next = OBJ_DETECT ? hit_inc : 5'h00;
      field_trip = OBJ_DETECT & (hit_inc >= need);
      if (cand_ok)
      begin
        case_next = cand;
        fset_next = nxt.fset;
      end
      in_err_next = ~cand_ok;
      cont_next = bad_reg | seg_bad;
      safe_next = cand_ok & ~field_trip & ~(bad_reg | seg_bad);
      if (safe_next)
        st_next = mcsel_pkg::ST_MONITOR;
      else if (st_reg != mcsel_pkg::ST_INIT || cand_ok)
        st_next = mcsel_pkg::ST_TRIPPED;
    end
    // Link report is always the inverse of the switching outputs
    intr_next = ~safe_next;
  end

  // ==========================================================
  // Registers
  // ==========================================================
  // Register the next values; outputs start tripped
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      st_reg <= mcsel_pkg::ST_INIT;
      case_reg <= `MCSEL_RST_CASE;
      fset_reg <= `MCSEL_RST_FSET;
      hit_reg <= 5'h00;
      bad_reg <= 1'b0;
      safe_reg <= 1'b0;
      intr_reg <= 1'b1;
      in_err_reg <= 1'b0;
      cont_reg <= 1'b0;
      rej_reg <= 1'b0;
    end
    else
    begin
      st_reg <= st_next;
      case_reg <= case_next;
      fset_reg <= fset_next;
      hit_reg <= hit_next;
      bad_reg <= bad_next;
      safe_reg <= safe_next;
      intr_reg <= intr_next;
      in_err_reg <= in_err_next;
      cont_reg <= cont_next;
      rej_reg <= rej_next;
    end
  end

  // Outputs straight from flip-flops
  assign SAFETY_SWITCH_OUTPUTS = safe_reg;
  // Own flip-flop, so no inverter sits between register and pin
  assign FIELD_INTERRUPTED = intr_reg;
  assign ACTIVE_CASE = case_reg;
  assign ACTIVE_FSET = fset_reg;
  assign INPUT_ERROR = in_err_reg;
  assign CONTOUR_ERROR = cont_reg;
  assign CFG_REJECT = rej_reg;

  // ==========================================================
  // Assertions
  // ==========================================================
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);
  sequence s_tick_bad_sel;
    SCAN_TICK && !cand_ok;
  endsequence
  sequence s_tick_ok_sel;
    SCAN_TICK && cand_ok;
  endsequence
  a_bin_decode: assert property (!ONE_OF_N_MODE |-> dec_idx == CTRL_IN)
    else $error("Complementary index differs from inputs");
  a_onen_error: assert property (
    ONE_OF_N_MODE && $countones(ONE_OF_N_IN) != 1 |-> !dec_ok)
    else $error("Bad 1-of-n pattern accepted");
  a_undef_trip: assert property (s_tick_bad_sel |=>
    !SAFETY_SWITCH_OUTPUTS && INPUT_ERROR)
    else $error("Undefined condition did not trip");
  a_case_load: assert property (s_tick_ok_sel |=>
    ACTIVE_CASE == $past(cand) && !INPUT_ERROR)
    else $error("Selected case not applied");
  a_case_boundary: assert property (
    $changed(ACTIVE_CASE) |-> $past(SCAN_TICK))
    else $error("Case changed between scan boundaries");
  a_obj_trip: assert property (SCAN_TICK && field_trip |=>
    !SAFETY_SWITCH_OUTPUTS ##0 FIELD_INTERRUPTED)
    else $error("Object did not trip outputs");
  a_first_hit: assert property (
    SCAN_TICK && OBJ_DETECT && hit_reg == 5'h00 |-> !field_trip)
    else $error("Single scan hit tripped outputs");
  a_contour_trip: assert property (
    first_match(SEG_STROBE && seg_bad ##[0:40] SCAN_TICK) |=> CONTOUR_ERROR)
    else $error("Contour fault not reported");
  a_cfg_reject: assert property (
    CFG_CONTOUR_EN && CFG_WARN2_EN |=> CFG_REJECT)
    else $error("Exclusive options accepted");
endmodule : mcsel_top

// ==== verification/mcsel_ctrl_model.sv ====
// Controller model that drives the static control inputs
`timescale 1ns/1ps
module mcsel_ctrl_model
(
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [2:0] slow,
  input wire logic [4:0] want_ctrl,
  input wire logic [9:0] want_pins,
  output logic [4:0] ctrl,
  output logic [9:0] pins,
  output logic settled
);
  // Cycles spent so far on the pending switch
  logic [2:0] wait_reg;
  // ==========
  // Switching
  // Bench starts a boundary only once both groups show the request
  assign settled = (ctrl == want_ctrl) && (pins == want_pins);
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      ctrl <= 5'h00;
      pins <= 10'h001;
      wait_reg <= 3'h0;
    end
    else if (!settled && wait_reg >= slow)
    begin
      ctrl <= want_ctrl;
      pins <= want_pins;
      wait_reg <= 3'h0;
    end
    else if (!settled)
      wait_reg <= wait_reg + 3'h1;
  end
endmodule : mcsel_ctrl_model

// ==== verification/tb.sv ====
// Self-checking bench of the monitoring case selector
`timescale 1ns/1ps
module tb;
  // ==========
  // Signals and model state
  logic ref_clk, rst_b, tick, onen, spd_v, we, cv, c_en, w2, wa, obj, stb;
  logic [4:0] want_c, spd_c, ci, fa, fb, mu, ctrl, act_case;
  logic [9:0] want_p, pins;
  logic [1:0] src, fo;
  logic [3:0] fs, act_fset;
  logic [15:0] meas, refd, tp, tn;
  logic [2:0] slow;
  logic safe, intr, in_err, ct_err, rej, settled;
  logic [12:0] stat;
  int num_errors, total_checks, seed, act, have, hits, cflag;
  int m_v[32], m_fs[32], m_fo[32], m_a[32], m_b[32], m_mu[32];
  int fol_seq[6] = '{2, 7, 2, 4, 10, 8};
  assign stat = {safe, intr, act_case, act_fset, in_err, ct_err};
  mcsel_ctrl_model ctl (.clk(ref_clk), .rst_b(rst_b), .slow(slow),
    .want_ctrl(want_c), .want_pins(want_p), .ctrl(ctrl), .pins(pins),
    .settled(settled));
  mcsel_top uut (.REF_CLK(ref_clk), .RST_B(rst_b), .SCAN_TICK(tick),
    .CTRL_IN(ctrl), .ONE_OF_N_IN(pins), .ONE_OF_N_MODE(onen),
    .SEL_SOURCE(src), .SPEED_CASE(spd_c), .SPEED_VALID(spd_v), .CFG_WE(we),
    .CFG_IDX(ci), .CFG_VALID(cv), .CFG_FSET(fs), .CFG_FOLLOW(fo),
    .CFG_FOLLOW_A(fa), .CFG_FOLLOW_B(fb), .CFG_MULTI(mu),
    .CFG_CONTOUR_EN(c_en), .CFG_WARN2_EN(w2), .CFG_WARN_AT_CONTOUR(wa),
    .OBJ_DETECT(obj), .SEG_STROBE(stb), .SEG_MEAS(meas), .SEG_REF(refd),
    .SEG_TOL_POS(tp), .SEG_TOL_NEG(tn), .SAFETY_SWITCH_OUTPUTS(safe),
    .FIELD_INTERRUPTED(intr), .ACTIVE_CASE(act_case),
    .ACTIVE_FSET(act_fset), .INPUT_ERROR(in_err), .CONTOUR_ERROR(ct_err),
    .CFG_REJECT(rej));
  // ==========
  // Compare and report tasks
  task automatic chk_scan(input logic [12:0] got, input logic [12:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected scan at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_scan
  task automatic chk_rej(input logic got, input logic exp);
    total_checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("unexpected reject at %0t: got %h exp %h", $time, got, exp);
    end
  endtask : chk_rej
  task automatic give_verdict;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : give_verdict
  // ==========
  // Drivers with the behavioural model alongside
  task automatic cfg(input int i, v, f, o, a, b, m);
    @(posedge ref_clk);
    we <= 1'b1;
    ci <= i[4:0];
    cv <= v[0];
    fs <= f[3:0];
    fo <= o[1:0];
    fa <= a[4:0];
    fb <= b[4:0];
    mu <= m[4:0];
    @(posedge ref_clk);
    we <= 1'b0;
    m_v[i] = v;
    m_fs[i] = f & 15;
    m_fo[i] = o;
    m_a[i] = a;
    m_b[i] = b;
    // Sampling count is clipped into its legal span when stored
    m_mu[i] = m < 2 ? 2 : (m > 16 ? 16 : m);
  endtask : cfg
  task automatic mode(input int on, s, v, c);
    @(posedge ref_clk);
    onen <= on[0];
    src <= s[1:0];
    spd_v <= v[0];
    spd_c <= c[4:0];
  endtask : mode
  task automatic strobe(input int v);
    @(posedge ref_clk);
    stb <= 1'b1;
    meas <= v[15:0];
    @(posedge ref_clk);
    stb <= 1'b0;
    if (c_en && !(w2 || wa) && (v > refd + tp || (refd >= tn && v < refd - tn)))
      cflag = 1;
  endtask : strobe
  task automatic tick_chk(input int c, p, o);
    int cand, m, n;
    logic bad, trip;
    logic [12:0] e;
    @(posedge ref_clk);
    want_c <= c[4:0];
    want_p <= p[9:0];
    obj <= o[0];
    slow <= 3'($random(seed) & 3);
    n = 0;
    // Bounded wait for the controller to finish its switch
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (settled !== 1'b1 && n < 20);
    tick <= 1'b1;
    @(posedge ref_clk);
    tick <= 1'b0;
    @(negedge ref_clk);
    cand = onen ? 0 : c;
    bad = onen && $countones(p[9:0]) != 1;
    for (int i = 0; i < 10; i++)
      if (onen && p[i])
        cand = i;
    case (src)
      2'h1:
      begin
        cand = spd_c;
        bad = !spd_v;
      end
      2'h2: bad = bad || !spd_v || cand != spd_c;
      2'h3: bad = 1'b1;
      default: ;
    endcase
    if (m_v[cand] == 0 || n >= 20)
      bad = 1'b1;
    if (have && cand != act && (m_fo[act] == 1 && cand != m_a[act] ||
        m_fo[act] == 2 && cand != m_a[act] && cand != m_b[act]))
      bad = 1'b1;
    hits = o ? (hits < 16 ? hits + 1 : 16) : 0;
    m = bad ? m_mu[act] : m_mu[cand];
    trip = hits >= m || bad || cflag;
    if (!bad)
    begin
      act = cand;
      have = 1;
    end
    e = {!trip, trip, 5'(act), 4'(m_fs[act]), bad, cflag[0]};
    chk_scan(stat, e);
    cflag = 0;
  endtask : tick_chk
  // ==========
  // Clock, watchdog and test sequence
  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // About 370 to 550 cycles are expected; allow about five times that
  initial
  begin
    #(3000 * 50);
    num_errors++;
    give_verdict();
  end
  initial
  begin
    seed = 32'h08bb6f93;
    {tick, onen, spd_v, we, cv, c_en, w2, wa, obj, stb, src, fo} = '0;
    {want_c, spd_c, ci, fa, fb, mu, fs, slow, meas, refd, tp, tn} = '0;
    want_p = 10'h001;
    rst_b = 1'b0;
    repeat (16) @(posedge ref_clk);
    rst_b <= 1'b1;
    @(negedge ref_clk);
    chk_scan(stat, 13'h0800);
    for (int i = 0; i < 32; i++)
      cfg(i, 1, $random(seed), 0, 0, 0, i);
    for (int i = 31; i >= 0; i--)
      tick_chk(i, 1, 0);
    $display("test complementary done");
    for (int k = 0; k < 3; k++)
      tick_chk(2, 1, k < 2);
    for (int k = 0; k < 17; k++)
      tick_chk(20, 1, 1);
    cfg(5, 0, 0, 0, 0, 0, 2);
    tick_chk(5, 1, 0);
    $display("test sampling done");
    mode(1, 0, 0, 0);
    for (int i = 0; i < 10; i++)
      tick_chk(0, 1 << i, 0);
    tick_chk(0, 0, 0);
    tick_chk(0, 3, 0);
    tick_chk(0, 24, 0);
    mode(0, 1, 1, 9);
    tick_chk(3, 1, 0);
    mode(0, 1, 0, 9);
    tick_chk(3, 1, 0);
    mode(0, 2, 1, 12);
    tick_chk(12, 1, 0);
    tick_chk(13, 1, 0);
    mode(0, 3, 1, 12);
    tick_chk(12, 1, 0);
    mode(0, 0, 0, 0);
    cfg(2, 1, 7, 1, 4, 0, 2);
    cfg(4, 1, 3, 2, 6, 8, 2);
    foreach (fol_seq[k])
      tick_chk(fol_seq[k], 1, 0);
    $display("test selection done");
    for (int k = 0; k < 8; k++)
    begin
      @(posedge ref_clk);
      {c_en, w2, wa} <= 3'(k);
      @(posedge ref_clk);
      @(negedge ref_clk);
      chk_rej(rej, k[2] & (k[1] | k[0]));
    end
    @(posedge ref_clk);
    {c_en, w2, wa} <= 3'h4;
    refd <= 16'h03e8;
    tp <= 16'h0032;
    tn <= 16'h0032;
    strobe(1020);
    tick_chk(8, 1, 0);
    strobe(1000);
    strobe(1051);
    strobe(1010);
    tick_chk(8, 1, 0);
    strobe(949);
    tick_chk(8, 1, 0);
    @(posedge ref_clk);
    refd <= 16'h0014;
    strobe(0);
    tick_chk(8, 1, 0);
    @(posedge ref_clk);
    w2 <= 1'b1;
    strobe(2000);
    tick_chk(8, 1, 0);
    $display("test contour done");
    give_verdict();
  end
endmodule : tb
